// >>> inc/cgi_regs.svh
// constants of the clock-generator serial register port
`ifndef CGI_REGS_SVH
`define CGI_REGS_SVH

// ----------------------------------------------------------------
// device addresses
// ----------------------------------------------------------------
`define CGI_CTRL_DEV_ADDR   7'h5C
`define CGI_EE_GROUP        4'hA
`define CGI_EE_GROUP_MSB    6
`define CGI_EE_GROUP_LSB    3

// ----------------------------------------------------------------
// map layout and reset values
// ----------------------------------------------------------------
`define CGI_NUM_BYTES       16
`define CGI_PTR_W           4
`define CGI_BYTE_RST        8'h00
`define CGI_PTR_RST         4'h0
`define CGI_ADDR_RW_BIT     0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CGI_CLK_SYS_HZ      10000000
`define CGI_EE_WRITE_MS     4
`define CGI_EE_WRITE_CYC    ((`CGI_EE_WRITE_MS * `CGI_CLK_SYS_HZ + 999) / 1000)
`define CGI_BUSY_W          16

`endif

// >>> inc/cgi_pkg.sv
// types of the clock-generator serial register port
package cgi_pkg;

	typedef logic [7:0] cgi_byte_t;

	// ----------------------------------------------------------------
	// link-side sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		CGI_ST_IDLE  = 5'b0_0001,
		CGI_ST_ADDR  = 5'b0_0010,
		CGI_ST_PTR   = 5'b0_0100,
		CGI_ST_WDATA = 5'b0_1000,
		CGI_ST_RDATA = 5'b1_0000
	} cgi_state_e;

endpackage

// >>> core/cgi_bank_cdc.sv
// carries the control byte bank from the serial clock into the system clock
`include "cgi_regs.svh"

module cgi_bank_cdc #(
	parameter int WIDTH = 128
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic             upd_tgl,
	input  wire logic [WIDTH-1:0] bank_in,
	output logic      [WIDTH-1:0] bank_q
);
	import cgi_pkg::*;

	logic upd_s1_q;
	logic upd_s2_q;
	logic upd_s3_q;

	// ----------------------------------------------------------------
	// toggle synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			upd_s1_q <= 1'b0;
			upd_s2_q <= 1'b0;
			upd_s3_q <= 1'b0;
		end else begin
			upd_s1_q <= upd_tgl;
			upd_s2_q <= upd_s1_q;
			upd_s3_q <= upd_s2_q;
		end
	end

	// ----------------------------------------------------------------
	// bank copy
	// ----------------------------------------------------------------
	// the bank was written on the same serial edge as the toggle, so it has
	// settled for two system cycles before the copy; a later write always
	// brings its own toggle, so a torn copy is repaired by the next one
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bank_q <= '0;
		end else if (upd_s2_q != upd_s3_q) begin
			bank_q <= bank_in;
		end
	end

endmodule // cgi_bank_cdc

// >>> core/cgi_i2c_slave.sv
// two-wire serial slave port for the control bytes and the nonvolatile store
// Operation
// - control bytes answer only to seven-bit address 1011100 followed by read/write bit
// - nonvolatile store answers to any address whose upper four bits are 1010
// - plain read/write slave; the general call address is never answered
// - transfers start only from an idle bus, both lines high
// - data falling while clock high is a start; every command opens with one
// - data rising while clock high is a stop; every command closes with one
// - data changes only while clock low; sampled once per clock high
// - receiver pulls data low on a ninth clock after each received byte
// - master withholds ack on last read byte; slave then releases data
// - write is address, register pointer, then data bytes, each acknowledged
// - stop or repeated start mid-byte discards the partial data
// - random read is pointer write, repeated start, read address, one byte
// - sequential control-byte write bumps the pointer per byte and wraps after sixteen
// - each written control byte is committed when it is acknowledged; a store byte waits for the stop
// - sequential read bumps the pointer per byte, wrapping past the last
// - the store's read pointer advances after every byte read
// - the control outputs follow the control bytes, same layout as the store
// - the port works only while the mode input is low
// - sixteen control bytes, all cleared at power-up
// - after a store write stop, the store addresses get no acknowledge for the 4 ms write cycle
`include "cgi_regs.svh"

module cgi_i2c_slave #(
	parameter int EE_WRITE_CYC = `CGI_EE_WRITE_CYC
) (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic         scl_clk,
	input  wire logic         sda_i,
	output logic              sda_o,
	output logic              sda_oe,
	input  wire logic         mode_run,
	output logic      [127:0] ctrl_bank,
	output logic              ee_busy
);
	import cgi_pkg::*;

	localparam int NB = `CGI_NUM_BYTES;
	localparam int PW = `CGI_PTR_W;

	// ----------------------------------------------------------------
	// serial clock domain: reset and mode synchronisers
	// ----------------------------------------------------------------
	logic rst_s1_q;
	logic rst_scl_n_q;
	logic mode_s1_q;
	logic mode_s2_q;
	logic busy_s1_q;
	logic busy_s2_q;

	// the serial clock stops between frames, so the master must clock a few
	// edges during reset for the serial side to clear
	always_ff @(posedge scl_clk) begin
		rst_s1_q    <= reset_n;
		rst_scl_n_q <= rst_s1_q;
	end

	always_ff @(posedge scl_clk) begin
		if (!rst_scl_n_q) begin
			mode_s1_q <= 1'b1;
			mode_s2_q <= 1'b1;
			busy_s1_q <= 1'b0;
			busy_s2_q <= 1'b0;
		end else begin
			mode_s1_q <= mode_run;
			mode_s2_q <= mode_s1_q;
			busy_s1_q <= ee_busy;
			busy_s2_q <= busy_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// start and stop detection
	// ----------------------------------------------------------------
	// a bus condition is a data edge with the clock high; no clock edge
	// follows a stop, so the data line itself clocks these two toggles
	logic start_tgl_q;
	logic stop_tgl_q;

	always_ff @(negedge sda_i or negedge rst_scl_n_q) begin
		if (!rst_scl_n_q) begin
			start_tgl_q <= 1'b0;
		end else if (scl_clk) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	always_ff @(posedge sda_i or negedge rst_scl_n_q) begin
		if (!rst_scl_n_q) begin
			stop_tgl_q <= 1'b0;
		end else if (scl_clk) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	// ----------------------------------------------------------------
	// bit sampling on the rising serial clock
	// ----------------------------------------------------------------
	cgi_byte_t  shift_q;
	logic       mack_q;

	always_ff @(posedge scl_clk) begin
		if (!rst_scl_n_q) begin
			shift_q <= `CGI_BYTE_RST;
			mack_q  <= 1'b1;
		end else begin
			shift_q <= {shift_q[6:0], sda_i};
			mack_q  <= sda_i;
		end
	end

	// ----------------------------------------------------------------
	// sequencer on the falling serial clock
	// ----------------------------------------------------------------
	cgi_state_e      state_q;
	logic [3:0]      bit_q;
	logic            start_seen_q;
	logic            stop_seen_q;
	logic            tgt_ee_q;
	logic            rw_q;
	logic [PW-1:0]   reg_ptr_q;
	logic [PW-1:0]   ee_ptr_q;
	cgi_byte_t       tx_q;
	logic            sda_oe_q;
	logic            sda_o_q;
	cgi_byte_t       regs_q [NB];
	cgi_byte_t       ee_mem_q [NB];
	logic            pend_v_q;
	logic [PW-1:0]   pend_addr_q;
	cgi_byte_t       pend_data_q;
	logic            upd_tgl_q;

	logic            start_ev;
	logic            stop_before;
	logic [6:0]      dev_addr;
	logic            hit_ctrl;
	logic            hit_ee;
	logic            byte_done;
	logic            ack_slot;
	logic            wr_ctrl;
	logic [PW-1:0]   rd_ptr;
	cgi_byte_t       rd_byte;
	logic [NB*8-1:0] ctrl_flat;

	assign start_ev    = start_tgl_q != start_seen_q;
	assign stop_before = stop_tgl_q != stop_seen_q;
	assign dev_addr    = shift_q[7:1];
	assign byte_done   = bit_q == 4'h7;
	assign ack_slot    = bit_q == 4'h8;
	// the general call address matches neither target by construction
	assign hit_ctrl    = dev_addr == `CGI_CTRL_DEV_ADDR;
	assign hit_ee      = (dev_addr[`CGI_EE_GROUP_MSB:`CGI_EE_GROUP_LSB] == `CGI_EE_GROUP)
		&& !busy_s2_q;
	assign wr_ctrl     = (state_q == CGI_ST_WDATA) && byte_done && !tgt_ee_q;
	assign rd_ptr      = tgt_ee_q ? ee_ptr_q : reg_ptr_q;
	assign rd_byte     = tgt_ee_q ? ee_mem_q[rd_ptr] : regs_q[rd_ptr];

	always_ff @(negedge scl_clk) begin
		if (!rst_scl_n_q) begin
			start_seen_q <= 1'b0;
			stop_seen_q  <= 1'b0;
		end else begin
			start_seen_q <= start_tgl_q;
			stop_seen_q  <= stop_tgl_q;
		end
	end

	always_ff @(negedge scl_clk) begin
		if (!rst_scl_n_q) begin
			state_q  <= CGI_ST_IDLE;
			bit_q    <= 4'h0;
			tgt_ee_q <= 1'b0;
			rw_q     <= 1'b0;
			tx_q     <= `CGI_BYTE_RST;
			sda_oe_q <= 1'b0;
		end else if (start_ev) begin
			// a repeated start also lands here; nothing half received is kept
			state_q  <= CGI_ST_ADDR;
			bit_q    <= 4'h0;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (state_q)
				CGI_ST_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				CGI_ST_ADDR: begin
					if (byte_done) begin
						bit_q <= 4'h8;
						// mode is judged here, not at the start: the serial clock is
						// stopped between frames, so only now has its synchroniser caught up
						if ((hit_ctrl || hit_ee) && !mode_s2_q) begin
							sda_oe_q <= 1'b1;
							tgt_ee_q <= !hit_ctrl;
							rw_q     <= shift_q[`CGI_ADDR_RW_BIT];
						end else begin
							state_q <= CGI_ST_IDLE;
						end
					end else if (ack_slot) begin
						bit_q <= 4'h0;
						if (rw_q) begin
							state_q  <= CGI_ST_RDATA;
							tx_q     <= {rd_byte[6:0], 1'b0};
							sda_oe_q <= !rd_byte[7];
						end else begin
							state_q  <= CGI_ST_PTR;
							sda_oe_q <= 1'b0;
						end
					end else begin
						bit_q <= bit_q + 4'h1;
					end
				end
				CGI_ST_PTR, CGI_ST_WDATA: begin
					if (byte_done) begin
						bit_q    <= 4'h8;
						sda_oe_q <= 1'b1;
					end else if (ack_slot) begin
						bit_q    <= 4'h0;
						sda_oe_q <= 1'b0;
						state_q  <= CGI_ST_WDATA;
					end else begin
						bit_q <= bit_q + 4'h1;
					end
				end
				CGI_ST_RDATA: begin
					if (byte_done) begin
						bit_q    <= 4'h8;
						sda_oe_q <= 1'b0;
					end else if (ack_slot) begin
						bit_q <= 4'h0;
						if (!mack_q) begin
							tx_q     <= {rd_byte[6:0], 1'b0};
							sda_oe_q <= !rd_byte[7];
						end else begin
							state_q  <= CGI_ST_IDLE;
							sda_oe_q <= 1'b0;
						end
					end else begin
						bit_q    <= bit_q + 4'h1;
						tx_q     <= {tx_q[6:0], 1'b0};
						sda_oe_q <= !tx_q[7];
					end
				end
				default: begin
					state_q  <= CGI_ST_IDLE;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// open drain: the pin is only ever pulled low
	always_ff @(negedge scl_clk) begin
		sda_o_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// pointers
	// ----------------------------------------------------------------
	always_ff @(negedge scl_clk) begin
		if (!rst_scl_n_q) begin
			reg_ptr_q <= `CGI_PTR_RST;
		end else if (!start_ev && !tgt_ee_q && byte_done) begin
			if (state_q == CGI_ST_PTR) begin
				reg_ptr_q <= shift_q[PW-1:0];
			end else if (state_q == CGI_ST_WDATA || state_q == CGI_ST_RDATA) begin
				reg_ptr_q <= reg_ptr_q + 4'h1;
			end
		end
	end

	always_ff @(negedge scl_clk) begin
		if (!rst_scl_n_q) begin
			ee_ptr_q <= `CGI_PTR_RST;
		end else if (!start_ev && tgt_ee_q && byte_done) begin
			if (state_q == CGI_ST_PTR) begin
				ee_ptr_q <= shift_q[PW-1:0];
			end else if (state_q == CGI_ST_RDATA) begin
				ee_ptr_q <= ee_ptr_q + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// control byte bank
	// ----------------------------------------------------------------
	generate
		for (genvar gi = 0; gi < NB; gi++) begin : g_reg
			always_ff @(negedge scl_clk) begin
				if (!rst_scl_n_q) begin
					regs_q[gi] <= `CGI_BYTE_RST;
				end else if (!start_ev && wr_ctrl && reg_ptr_q == PW'(gi)) begin
					regs_q[gi] <= shift_q;
				end
			end
			assign ctrl_flat[gi*8 +: 8] = regs_q[gi];
		end
	endgenerate

	always_ff @(negedge scl_clk) begin
		if (!rst_scl_n_q) begin
			upd_tgl_q <= 1'b0;
		end else if (!start_ev && wr_ctrl) begin
			upd_tgl_q <= ~upd_tgl_q;
		end
	end

	// ----------------------------------------------------------------
	// nonvolatile store: one pending byte, committed once a stop closes it
	// ----------------------------------------------------------------
	always_ff @(negedge scl_clk) begin
		if (!rst_scl_n_q) begin
			pend_v_q    <= 1'b0;
			pend_addr_q <= `CGI_PTR_RST;
			pend_data_q <= `CGI_BYTE_RST;
		end else if (start_ev) begin
			pend_v_q <= 1'b0;
		end else if (state_q == CGI_ST_WDATA && byte_done && tgt_ee_q) begin
			// a further byte replaces the loaded one; the store has no
			// sequential write
			pend_v_q    <= 1'b1;
			pend_addr_q <= ee_ptr_q;
			pend_data_q <= shift_q;
		end
	end

	// the commit lands on the first serial edge after the stop, which is the
	// next frame's start; the store is held busy from the stop onward
	generate
		for (genvar ge = 0; ge < NB; ge++) begin : g_ee
			always_ff @(negedge scl_clk) begin
				if (!rst_scl_n_q) begin
					ee_mem_q[ge] <= `CGI_BYTE_RST;
				end else if (start_ev && stop_before && pend_v_q
					&& pend_addr_q == PW'(ge)) begin
					ee_mem_q[ge] <= pend_data_q;
				end
			end
		end
	endgenerate

	assign sda_oe = sda_oe_q;
	assign sda_o  = sda_o_q;

	// ----------------------------------------------------------------
	// system clock domain: stop and pending-write crossing
	// ----------------------------------------------------------------
	logic stop_s1_q;
	logic stop_s2_q;
	logic stop_s3_q;
	logic pend_s1_q;
	logic pend_s2_q;
	logic [`CGI_BUSY_W-1:0] busy_cnt_q;
	logic ee_busy_q;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			stop_s1_q <= 1'b0;
			stop_s2_q <= 1'b0;
			stop_s3_q <= 1'b0;
			pend_s1_q <= 1'b0;
			pend_s2_q <= 1'b0;
		end else begin
			stop_s1_q <= stop_tgl_q;
			stop_s2_q <= stop_s1_q;
			stop_s3_q <= stop_s2_q;
			pend_s1_q <= pend_v_q;
			pend_s2_q <= pend_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// store write-cycle timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			busy_cnt_q <= '0;
			ee_busy_q  <= 1'b0;
		end else if (stop_s2_q != stop_s3_q && pend_s2_q) begin
			busy_cnt_q <= `CGI_BUSY_W'(EE_WRITE_CYC - 1);
			ee_busy_q  <= 1'b1;
		end else if (busy_cnt_q != '0) begin
			busy_cnt_q <= busy_cnt_q - `CGI_BUSY_W'(1);
		end else begin
			ee_busy_q <= 1'b0;
		end
	end

	assign ee_busy = ee_busy_q;

	// ----------------------------------------------------------------
	// control bank towards the clock generator
	// ----------------------------------------------------------------
	cgi_bank_cdc #(
		.WIDTH (NB*8)
	) u_bank_cdc (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.upd_tgl (upd_tgl_q),
		.bank_in (ctrl_flat),
		.bank_q  (ctrl_bank)
	);

endmodule // cgi_i2c_slave

// >>> verif/cgi_i2c_slave_chk.sv
// assertions on the serial register port, bound to its top module
module cgi_i2c_slave_chk #(
	parameter int EE_WRITE_CYC = 20
) (
	input wire logic         clk_sys,
	input wire logic         reset_n,
	input wire logic         scl_clk,
	input wire logic         sda_i,
	input wire logic         sda_o,
	input wire logic         sda_oe,
	input wire logic         mode_run,
	input wire logic [127:0] ctrl_bank,
	input wire logic         ee_busy
);
	logic [15:0] rise_q;
	logic [15:0] mark_q;
	logic [15:0] busy_q;
	logic [7:0]  sh_q;
	logic        oe_rise_q;
	logic        addr_done;

	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	// remember the clock count at each start; no reset here, it only fires on a start
	always_ff @(negedge sda_i) begin
		if (scl_clk)
			mark_q <= rise_q;
	end
	always_ff @(posedge scl_clk) begin
		if (!reset_n) begin
			rise_q <= '0;
			sh_q <= '0;
			oe_rise_q <= 1'b0;
		end else begin
			rise_q <= rise_q + 16'd1;
			sh_q <= {sh_q[6:0], sda_i};
			oe_rise_q <= sda_oe;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !ee_busy)
			busy_q <= '0;
		else
			busy_q <= busy_q + 16'd1;
	end
	// true on the ninth clock after a start, when the address byte is complete
	assign addr_done = (rise_q - mark_q) == 16'd8;

	// ------------------------------------------------------------
	// serial side
	// ------------------------------------------------------------
	oe_steady_a: assert property (@(negedge scl_clk) disable iff (!reset_n)
		sda_oe == oe_rise_q) else $error("data pin moved while clock high");
	ctrl_ack_a: assert property (@(posedge scl_clk) disable iff (!reset_n)
		addr_done && sh_q[7:1] == 7'h5c && !mode_run |-> sda_oe)
		else $error("control address not acknowledged");
	foreign_nak_a: assert property (@(posedge scl_clk) disable iff (!reset_n)
		addr_done && sh_q[7:1] != 7'h5c && sh_q[7:4] != 4'ha |-> !sda_oe)
		else $error("foreign address acknowledged");
	run_quiet_a: assert property (@(posedge scl_clk) disable iff (!reset_n)
		mode_run |-> !sda_oe) else $error("port answered in run mode");
	read_release_a: assert property (@(posedge scl_clk) disable iff (!reset_n)
		sda_oe [*8] ##1 sda_oe |=> !sda_oe) else $error("data pin held too long");

	// ------------------------------------------------------------
	// system side
	// ------------------------------------------------------------
	reset_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(reset_n) |-> ctrl_bank == '0 && !ee_busy) else $error("bank not cleared");
	busy_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(ee_busy) |-> busy_q >= EE_WRITE_CYC - 1 && busy_q <= EE_WRITE_CYC + 1)
		else $error("store busy length wrong");
	open_drain_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sda_o == 1'b0) else $error("data pin driven high");
	run_bank_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		mode_run [*6] |=> $stable(ctrl_bank)) else $error("bank moved in run mode");

	ctrl_ack_c: cover property (@(posedge scl_clk) addr_done && sda_oe);
	busy_c: cover property (@(posedge clk_sys) $rose(ee_busy));
	release_c: cover property (@(posedge scl_clk) sda_oe [*8] ##1 !sda_oe);
endmodule // cgi_i2c_slave_chk

bind cgi_i2c_slave cgi_i2c_slave_chk #(.EE_WRITE_CYC(EE_WRITE_CYC)) chk_i (
	.clk_sys(clk_sys), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .mode_run(mode_run), .ctrl_bank(ctrl_bank),
	.ee_busy(ee_busy));

// >>> verif/cgi_bus_master.sv
// bus master model driving the serial clock and data line, 30 ns per bit
module cgi_bus_master (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;

	// released lines sit at the pull-up level
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// data moves only while the clock is low, sampled mid high phase
	task automatic clk_bit(input logic v, output logic s);
		scl = 1'b0;
		#7 sda_m = v;
		#8 scl = 1'b1;
		#7 s = sda;
		#8;
	endtask
	// from idle only the data falls; otherwise a repeated start
	task automatic start();
		if (!(scl && sda)) begin
			scl = 1'b0;
			#7 sda_m = 1'b1;
			#8 scl = 1'b1;
		end
		#7 sda_m = 1'b0;
		#8;
	endtask
	task automatic stop();
		scl = 1'b0;
		#7 sda_m = 1'b0;
		#8 scl = 1'b1;
		#7 sda_m = 1'b1;
		#8;
	endtask
	// n below 8 leaves a partial byte with no ninth clock
	task automatic send(input logic [7:0] v, input int n, output logic ack);
		logic s;
		ack = 1'b0;
		for (int i = 7; i > 7 - n; i--)
			clk_bit(v[i], s);
		if (n == 8) begin
			clk_bit(1'b1, s);
			ack = ~s;
		end
	endtask
	task automatic recv(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, v[i]);
		clk_bit(last, s);
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			#15 scl = 1'b0;
			#15 scl = 1'b1;
		end
	endtask
endmodule // cgi_bus_master

// >>> verif/clock_gen_i2c_register_slave_tb.sv
// self-checking bench for the serial register port
module clock_gen_i2c_register_slave_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BUSY_CYC = 20;
	logic         clk_sys = 1'b0;
	logic         reset_n = 1'b0;
	logic         mode_run = 1'b0;
	logic         scl_clk;
	logic         sda_m;
	logic         sda_o;
	logic         sda_oe;
	logic         ee_busy;
	logic         ack;
	logic         sda_w;
	logic [7:0]   rd;
	logic [127:0] ctrl_bank;
	logic [127:0] exp_bank = '0;
	int           n_errors = 0;
	int           samples_checked = 0;

	assign sda_w = sda_oe ? 1'b0 : sda_m;
	always #50 clk_sys = ~clk_sys;

	cgi_bus_master m (.scl(scl_clk), .sda_m(sda_m), .sda(sda_w));
	cgi_i2c_slave #(.EE_WRITE_CYC(BUSY_CYC)) dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .mode_run(mode_run), .ctrl_bank(ctrl_bank),
		.ee_busy(ee_busy));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// the bank mirror lags the serial side by a few system cycles
	task automatic settle();
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic set_ptr(input logic [6:0] dev, input logic [7:0] ptr);
		m.start();
		m.send({dev, 1'b0}, 8, ack);
		chk("address ack", ack, 1'b1);
		m.send(ptr, 8, ack);
		chk("pointer ack", ack, 1'b1);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_seq_write();
		set_ptr(7'h5c, 8'hfe);
		for (int k = 0; k < 18; k++) begin
			m.send(8'h10 + k[7:0], 8, ack);
			chk("data ack", ack, 1'b1);
			exp_bank[8 * ((14 + k) % 16) +: 8] = 8'h10 + k[7:0];
			if (k == 0) begin
				settle();
				chk("bank before stop", ctrl_bank, exp_bank);
			end
		end
		m.stop();
		settle();
		chk("bank after wrap", ctrl_bank, exp_bank);
	endtask
	task automatic t_abort();
		set_ptr(7'h5c, 8'h02);
		m.send(8'hff, 4, ack);
		m.stop();
		set_ptr(7'h5c, 8'h03);
		m.send(8'h55, 5, ack);
		m.start();
		m.stop();
		settle();
		chk("bank after abort", ctrl_bank, exp_bank);
	endtask
	task automatic t_read();
		set_ptr(7'h5c, 8'h0e);
		m.start();
		m.send({7'h5c, 1'b1}, 8, ack);
		chk("read address ack", ack, 1'b1);
		for (int k = 0; k < 17; k++) begin
			m.recv(k == 16, rd);
			chk("read byte", rd, exp_bank[8 * ((14 + k) % 16) +: 8]);
		end
		m.stop();
		chk("released after nack", sda_oe, 1'b0);
	endtask
	task automatic t_refuse();
		logic [6:0] bad [4] = '{7'h00, 7'h5d, 7'h1c, 7'h2e};
		foreach (bad[i]) begin
			m.start();
			m.send({bad[i], 1'b0}, 8, ack);
			chk("foreign ack", ack, 1'b0);
			m.stop();
		end
		@(posedge clk_sys) mode_run <= 1'b1;
		settle();
		m.start();
		m.send({7'h5c, 1'b0}, 8, ack);
		chk("run mode ack", ack, 1'b0);
		m.stop();
		@(posedge clk_sys) mode_run <= 1'b0;
		settle();
	endtask
	task automatic t_store();
		set_ptr(7'h53, 8'h05);
		m.send(8'h3c, 8, ack);
		chk("store data ack", ack, 1'b1);
		m.stop();
		settle();
		chk("store busy", ee_busy, 1'b1);
		m.start();
		m.send({7'h50, 1'b0}, 8, ack);
		chk("busy poll ack", ack, 1'b0);
		m.stop();
		repeat (BUSY_CYC + 4) @(posedge clk_sys);
		chk("busy over", ee_busy, 1'b0);
		set_ptr(7'h57, 8'h05);
		m.start();
		m.send({7'h57, 1'b1}, 8, ack);
		chk("store read ack", ack, 1'b1);
		m.recv(1'b0, rd);
		chk("store byte", rd, 8'h3c);
		m.recv(1'b1, rd);
		chk("store next byte", rd, 8'h00);
		m.stop();
		settle();
		chk("bank untouched by store", ctrl_bank, exp_bank);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		fork
			m.idle(40);
		join_none
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		settle();
		chk("reset bank", ctrl_bank, exp_bank);
		chk("reset busy", ee_busy, 1'b0);
		chk("reset data pin", sda_oe, 1'b0);
		t_seq_write();
		t_abort();
		t_read();
		t_refuse();
		t_store();
		close_out();
	end
	initial begin
		#300000;
		n_errors++;
		close_out();
	end
endmodule // clock_gen_i2c_register_slave_tb
